// file: logic/fpm_consts.svh
// Timing figures and field positions for the page-mode DRAM controller
`ifndef FPM_CONSTS_SVH
`define FPM_CONSTS_SVH

// Core clock period
`define FPM_CLK_NS 20
// Slowest speed grade, so any grade on the module is served
`define FPM_RANDOM_CYCLE_TIME_NS 180
`define FPM_PAGE_CYCLE_TIME_NS 55
`define FPM_ROW_LOW_MIN_NS 100
`define FPM_PAGE_ROW_LOW_WIDTH_NS 100000
`define FPM_ROW_PRECHARGE_NS 70
`define FPM_ROW_TO_COLUMN_DELAY_NS 25
`define FPM_COLUMN_ACCESS_TIME_NS 25
`define FPM_WRITE_DATA_HOLD_NS 20
`define FPM_COLUMN_STROBE_HIGH_TIME_NS 15
`define FPM_REFRESH_SETUP_NS 10
`define FPM_POWER_UP_US 100
`define FPM_REFRESH_INTERVAL_MS 8
`define FPM_REFRESH_ROWS 512
`define FPM_WAKE_CYCLES 8
`define FPM_SYNC_STAGES 2
// Cycles kept in hand before the longest row-low time
`define FPM_PAGE_GUARD 8

// Least times round up, longest times round down
`define FPM_CEIL_CYC(ns) (((ns) + `FPM_CLK_NS - 1) / `FPM_CLK_NS)
`define FPM_FLOOR_CYC(ns) ((ns) / `FPM_CLK_NS)

`define FPM_RC_CYC `FPM_CEIL_CYC(`FPM_RANDOM_CYCLE_TIME_NS)
`define FPM_PC_CYC `FPM_CEIL_CYC(`FPM_PAGE_CYCLE_TIME_NS)
`define FPM_ROW_LOW_MIN_CYC `FPM_CEIL_CYC(`FPM_ROW_LOW_MIN_NS)
`define FPM_RCD_CYC `FPM_CEIL_CYC(`FPM_ROW_TO_COLUMN_DELAY_NS)
`define FPM_CPN_CYC `FPM_CEIL_CYC(`FPM_COLUMN_STROBE_HIGH_TIME_NS)
`define FPM_CSR_CYC `FPM_CEIL_CYC(`FPM_REFRESH_SETUP_NS)
`define FPM_DH_CYC `FPM_CEIL_CYC(`FPM_WRITE_DATA_HOLD_NS)
`define FPM_RP_MIN_CYC `FPM_CEIL_CYC(`FPM_ROW_PRECHARGE_NS)
// Precharge also tops the row-low time up to a full random cycle
`define FPM_RP_CYC ((`FPM_RP_MIN_CYC > (`FPM_RC_CYC - `FPM_ROW_LOW_MIN_CYC)) \
  ? `FPM_RP_MIN_CYC : (`FPM_RC_CYC - `FPM_ROW_LOW_MIN_CYC))
// Write column low long enough that the row meets its least low time
`define FPM_COL_WR_CYC (`FPM_ROW_LOW_MIN_CYC - `FPM_RCD_CYC)
// Read column low covers access time plus the input synchroniser
`define FPM_COL_RD_CYC \
  (`FPM_CEIL_CYC(`FPM_COLUMN_ACCESS_TIME_NS) + `FPM_SYNC_STAGES)
`define FPM_REF_TICK_CYC \
  ((`FPM_REFRESH_INTERVAL_MS * 1000000) / `FPM_REFRESH_ROWS / `FPM_CLK_NS)

// Word address split into row and column halves
`define FPM_ROW_LSB 10
`define FPM_COL_LSB 0
`define FPM_HALF_W 10

`endif

// file: logic/fpm_pkg.sv
// Types shared by the page-mode DRAM controller modules
package fpm_pkg;
  typedef logic [18:0] fpm_cnt_t;
  typedef logic [19:0] fpm_word_addr_t;
  typedef logic [9:0] fpm_half_t;
  typedef logic [7:0] fpm_byte_t;
  typedef logic [3:0] fpm_wake_cnt_t;
  typedef logic [7:0] fpm_gap_t;
  typedef enum logic [3:0] {
    ST_PWR, ST_WAKE_LO, ST_WAKE_HI, ST_IDLE, ST_ROW, ST_COL, ST_OPEN,
    ST_CAS_HI, ST_PRE, ST_REF_CAS, ST_REF_HID, ST_REF_RAS
  } fpm_state_t;
endpackage

// file: logic/fpm_tmr_if.sv
// Load and expiry signals between the sequencer and its delay timer
interface fpm_tmr_if;
  logic load;
  fpm_pkg::fpm_cnt_t load_val;
  logic done;
  modport ctrl (output load, output load_val, input done);
  modport tmr (input load, input load_val, output done);
endinterface

// file: logic/fpm_timer.sv
// Down counter that times each sequencer state
module fpm_timer #(
  parameter fpm_pkg::fpm_cnt_t RST_VAL = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Sequencer side
  fpm_tmr_if.tmr tmr
);
  fpm_pkg::fpm_cnt_t count; // Cycles left in the current state

  // Expired once the count reaches zero
  assign tmr.done = (count == '0);

  // Reload on a state change, else count down to zero
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count <= RST_VAL;
    end
    else if (tmr.load)
    begin
      count <= tmr.load_val;
    end
    else if (count != '0)
    begin
      count <= count - 1'b1;
    end
  end
endmodule

// file: logic/fpm_ctrl.sv
// Controller that drives a page-mode DRAM module through its pins
// How it works
// - Keep a full random cycle between row strobes
// - Space page-mode column strobes by page cycle
// - Row low between least and longest width
// - Power-up pause, then eight row strobe cycles
// - Repeat wake-up when refresh interval is overrun
// - Column strobe high before a fresh cycle
// - Write enable stays high past read strobes
// - Only early writes, enable before column
// - Hold write data after column strobe falls
// - Hidden refresh follows access, column kept low
// - Row half then column half on address
// - Write enable high reads, low writes
// - Every row refreshed within refresh interval
`include "fpm_consts.svh"
module fpm_ctrl #(
  parameter int PWR_CYC =
    `FPM_CEIL_CYC(`FPM_POWER_UP_US * 1000),
  parameter int PAGE_MAX_CYC = `FPM_FLOOR_CYC(`FPM_PAGE_ROW_LOW_WIDTH_NS),
  parameter int REF_INT_CYC =
    `FPM_FLOOR_CYC(`FPM_REFRESH_INTERVAL_MS * 1000000)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire fpm_pkg::fpm_word_addr_t req_addr,
  input wire fpm_pkg::fpm_byte_t req_wdata,
  // User read answer and status
  output logic rd_valid,
  output fpm_pkg::fpm_byte_t rd_data,
  output logic init_done,
  // DRAM strobes and address
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic write_enable_n,
  output fpm_pkg::fpm_half_t multiplexed_address_lines,
  // DRAM two-way data
  input wire fpm_pkg::fpm_byte_t shared_data_lines_in,
  output fpm_pkg::fpm_byte_t shared_data_lines_out,
  output logic shared_data_lines_oe
);
  localparam int RC_CYC = `FPM_RC_CYC;
  localparam int PC_CYC = `FPM_PC_CYC;
  localparam int RAS_MIN = `FPM_ROW_LOW_MIN_CYC;
  localparam int WAKE_N = `FPM_WAKE_CYCLES;
  localparam int TICK_CYC = `FPM_REF_TICK_CYC;

  fpm_tmr_if tmr(); // State delay timer link
  fpm_pkg::fpm_state_t state; // Sequencer state
  fpm_pkg::fpm_state_t next_state;
  fpm_pkg::fpm_byte_t dq_meta; // First synchroniser stage
  fpm_pkg::fpm_byte_t dq_sync; // Second synchroniser stage
  logic held; // Accepted request waits for service
  logic cur_write; // Accepted request kind
  fpm_pkg::fpm_word_addr_t cur_addr; // Accepted request address
  fpm_pkg::fpm_byte_t cur_wdata; // Accepted write byte
  fpm_pkg::fpm_half_t open_row; // Row held open in page mode
  fpm_pkg::fpm_wake_cnt_t wake_cnt; // Wake-up row cycles issued
  fpm_pkg::fpm_cnt_t ras_lo_cnt; // Cycles the row strobe has been low
  fpm_pkg::fpm_cnt_t tick_cnt; // Per-row refresh spacing
  fpm_pkg::fpm_cnt_t stale_cnt; // Cycles since the last refresh
  logic ref_pending; // A refresh is owed
  logic wake_req; // Refresh overrun, wake-up again
  int next_len; // Length of the state being entered

  // Decoded conditions
  wire accept = req_valid && req_ready;
  wire changing = (next_state != state);
  wire enter_row = changing && (next_state == fpm_pkg::ST_ROW);
  wire enter_chi = changing && (next_state == fpm_pkg::ST_CAS_HI);
  wire enter_col_addr = enter_row || enter_chi;
  wire fpm_pkg::fpm_half_t cur_row = cur_addr[`FPM_ROW_LSB +: `FPM_HALF_W];
  wire fpm_pkg::fpm_half_t cur_col = cur_addr[`FPM_COL_LSB +: `FPM_HALF_W];
  wire same_row = (cur_row == open_row);
  wire page_lim = (ras_lo_cnt >=
    fpm_pkg::fpm_cnt_t'(PAGE_MAX_CYC - `FPM_PAGE_GUARD));
  wire ref_done = (state == fpm_pkg::ST_REF_RAS) && tmr.done;
  wire tick = (tick_cnt == fpm_pkg::fpm_cnt_t'(TICK_CYC - 1));
  wire stale = (stale_cnt == fpm_pkg::fpm_cnt_t'(REF_INT_CYC - 1));
  wire wake_last = (wake_cnt == fpm_pkg::fpm_wake_cnt_t'(WAKE_N));
  wire rd_done = (state == fpm_pkg::ST_COL) && tmr.done && !cur_write;

  // Next pin levels
  wire next_ras_n = !(next_state inside {fpm_pkg::ST_ROW, fpm_pkg::ST_COL,
    fpm_pkg::ST_OPEN, fpm_pkg::ST_CAS_HI, fpm_pkg::ST_WAKE_LO,
    fpm_pkg::ST_REF_RAS});
  wire next_cas_n = !(next_state inside {fpm_pkg::ST_COL,
    fpm_pkg::ST_REF_CAS, fpm_pkg::ST_REF_RAS, fpm_pkg::ST_REF_HID});
  wire next_init = !(next_state inside {fpm_pkg::ST_PWR,
    fpm_pkg::ST_WAKE_LO, fpm_pkg::ST_WAKE_HI});
  wire next_held = accept || (held && !enter_col_addr);
  wire next_ready = (next_state inside {fpm_pkg::ST_IDLE,
    fpm_pkg::ST_OPEN}) && !next_held;
  // Row half first, column half from the second row cycle on
  wire fpm_pkg::fpm_half_t next_addr = enter_row ? cur_row :
    (next_state inside {fpm_pkg::ST_ROW, fpm_pkg::ST_CAS_HI}) ? cur_col :
    multiplexed_address_lines;
  // Write enable set before the column strobe can fall
  wire next_we_n = enter_col_addr ? !cur_write : write_enable_n;
  // Drive data through the column low time and the row or column-high state before
  wire next_oe = cur_write && (next_state inside {fpm_pkg::ST_ROW,
    fpm_pkg::ST_CAS_HI, fpm_pkg::ST_COL});

  // State lengths in cycles
  assign next_len =
    (next_state == fpm_pkg::ST_PWR) ? PWR_CYC :
    (next_state == fpm_pkg::ST_WAKE_LO) ? RAS_MIN :
    (next_state == fpm_pkg::ST_ROW) ? `FPM_RCD_CYC :
    (next_state == fpm_pkg::ST_COL) ?
      (cur_write ? `FPM_COL_WR_CYC : `FPM_COL_RD_CYC) :
    (next_state == fpm_pkg::ST_CAS_HI) ? `FPM_CPN_CYC :
    (next_state == fpm_pkg::ST_REF_CAS) ? `FPM_CSR_CYC :
    (next_state == fpm_pkg::ST_REF_RAS) ? RAS_MIN :
    (next_state inside {fpm_pkg::ST_WAKE_HI, fpm_pkg::ST_PRE,
      fpm_pkg::ST_REF_HID}) ? `FPM_RP_CYC : 1;
  assign tmr.load = changing;
  assign tmr.load_val = fpm_pkg::fpm_cnt_t'(next_len - 1);

  // Delay timer, loaded with the power-up pause at reset
  fpm_timer #(
    .RST_VAL(fpm_pkg::fpm_cnt_t'(PWR_CYC - 1))
  ) u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tmr(tmr)
  );

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    case (state)
      fpm_pkg::ST_PWR: if (tmr.done) next_state = fpm_pkg::ST_WAKE_LO;
      fpm_pkg::ST_WAKE_LO: if (tmr.done) next_state = fpm_pkg::ST_WAKE_HI;
      fpm_pkg::ST_WAKE_HI:
      begin
        // Eight row cycles before normal accesses
        if (tmr.done)
          next_state = wake_last ? fpm_pkg::ST_IDLE : fpm_pkg::ST_WAKE_LO;
      end
      fpm_pkg::ST_IDLE:
      begin
        // Wake-up again, then refresh, then the user
        if (wake_req)
          next_state = fpm_pkg::ST_WAKE_LO;
        else if (ref_pending)
          next_state = fpm_pkg::ST_REF_CAS;
        else if (held)
          next_state = fpm_pkg::ST_ROW;
      end
      fpm_pkg::ST_ROW: if (tmr.done) next_state = fpm_pkg::ST_COL;
      fpm_pkg::ST_COL:
      begin
        // Owed refresh hides behind the access
        if (tmr.done)
          next_state = ref_pending ? fpm_pkg::ST_REF_HID
            : fpm_pkg::ST_OPEN;
      end
      fpm_pkg::ST_OPEN:
      begin
        // Close for refresh, page limit or a new row
        if (ref_pending || page_lim)
          next_state = fpm_pkg::ST_PRE;
        else if (held && same_row)
          next_state = fpm_pkg::ST_CAS_HI;
        else if (held)
          next_state = fpm_pkg::ST_PRE;
      end
      fpm_pkg::ST_CAS_HI: if (tmr.done) next_state = fpm_pkg::ST_COL;
      fpm_pkg::ST_PRE: if (tmr.done) next_state = fpm_pkg::ST_IDLE;
      fpm_pkg::ST_REF_CAS: if (tmr.done) next_state = fpm_pkg::ST_REF_RAS;
      fpm_pkg::ST_REF_HID: if (tmr.done) next_state = fpm_pkg::ST_REF_RAS;
      fpm_pkg::ST_REF_RAS: if (tmr.done) next_state = fpm_pkg::ST_PRE;
      default: next_state = fpm_pkg::ST_IDLE;
    endcase
  end

  // Data input synchroniser
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dq_meta <= '0;
      dq_sync <= '0;
    end
    else
    begin
      dq_meta <= shared_data_lines_in;
      dq_sync <= dq_meta;
    end
  end

  // State and pin registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= fpm_pkg::ST_PWR;
      row_strobe_n <= 1'b1;
      column_strobe_n <= 1'b1;
      write_enable_n <= 1'b1;
      multiplexed_address_lines <= '0;
      shared_data_lines_oe <= 1'b0;
      shared_data_lines_out <= '0;
      init_done <= 1'b0;
      req_ready <= 1'b0;
    end
    else
    begin
      state <= next_state;
      row_strobe_n <= next_ras_n;
      column_strobe_n <= next_cas_n;
      write_enable_n <= next_we_n;
      multiplexed_address_lines <= next_addr;
      shared_data_lines_oe <= next_oe;
      if (enter_col_addr)
        shared_data_lines_out <= cur_wdata;
      init_done <= next_init;
      req_ready <= next_ready;
    end
  end

  // Request holding and read answer
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      held <= 1'b0;
      cur_write <= 1'b0;
      cur_addr <= '0;
      cur_wdata <= '0;
      open_row <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end
    else
    begin
      held <= next_held;
      if (accept)
      begin
        cur_write <= req_write;
        cur_addr <= req_addr;
        cur_wdata <= req_wdata;
      end
      if (enter_row)
        open_row <= cur_row;
      rd_valid <= rd_done;
      if (rd_done)
        rd_data <= dq_sync;
    end
  end

  // Refresh pacing, overrun watch and wake-up count
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_cnt <= '0;
      stale_cnt <= '0;
      ref_pending <= 1'b0;
      wake_req <= 1'b0;
      wake_cnt <= '0;
      ras_lo_cnt <= '0;
    end
    else
    begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      // New tick wins over a finishing refresh
      ref_pending <= tick || (ref_pending && !ref_done);
      if (ref_done || !init_done)
        stale_cnt <= '0;
      else if (!stale)
        stale_cnt <= stale_cnt + 1'b1;
      // Overrun wins over the wake-up start that clears it
      wake_req <= (stale && init_done) ||
        (wake_req && !(changing && next_state == fpm_pkg::ST_WAKE_LO));
      if (changing && next_state == fpm_pkg::ST_WAKE_LO)
        wake_cnt <= (state == fpm_pkg::ST_WAKE_HI) ? wake_cnt + 1'b1 : 4'h1;
      ras_lo_cnt <= next_ras_n ? '0 :
        (row_strobe_n ? fpm_pkg::fpm_cnt_t'(1) : ras_lo_cnt + 1'b1);
    end
  end

  // Checking aids: gaps between strobe falls, wake-up falls
  fpm_pkg::fpm_gap_t ras_gap;
  fpm_pkg::fpm_gap_t cas_gap;
  fpm_pkg::fpm_wake_cnt_t wake_falls;
  fpm_pkg::fpm_cnt_t since_rst;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ras_gap <= 8'hff;
      cas_gap <= 8'hff;
      wake_falls <= '0;
      since_rst <= '0;
    end
    else
    begin
      ras_gap <= ($fell(row_strobe_n)) ? 8'h01 :
        (ras_gap == 8'hff) ? ras_gap : ras_gap + 1'b1;
      cas_gap <= ($fell(column_strobe_n)) ? 8'h01 :
        (cas_gap == 8'hff) ? cas_gap : cas_gap + 1'b1;
      wake_falls <= init_done ? '0 : ($fell(row_strobe_n) &&
        wake_falls != 4'hf) ? wake_falls + 1'b1 : wake_falls;
      if (since_rst != 19'h7ffff)
        since_rst <= since_rst + 1'b1;
    end
  end

  property p_rc;
    @(posedge core_clk) disable iff (sys_rst)
    $fell(row_strobe_n) |-> ras_gap >= RC_CYC;
  endproperty
  a_rc: assert property (p_rc)
    else $error("Row strobe cycle shorter than random cycle time");

  property p_pc;
    @(posedge core_clk) disable iff (sys_rst)
    $fell(column_strobe_n) && !row_strobe_n |-> cas_gap >= PC_CYC;
  endproperty
  a_pc: assert property (p_pc)
    else $error("Page column cycle shorter than page cycle time");

  property p_ras_width;
    @(posedge core_clk) disable iff (sys_rst)
    $rose(row_strobe_n) |-> $past(ras_lo_cnt) >= RAS_MIN &&
      $past(ras_lo_cnt) <= PAGE_MAX_CYC;
  endproperty
  a_ras_width: assert property (p_ras_width)
    else $error("Row strobe low width out of bounds");

  property p_wake;
    @(posedge core_clk) disable iff (sys_rst)
    $rose(init_done) |-> wake_falls >= WAKE_N && since_rst >= PWR_CYC;
  endproperty
  a_wake: assert property (p_wake)
    else $error("Accesses enabled before wake-up finished");

  property p_rewake;
    @(posedge core_clk) disable iff (sys_rst)
    (state == fpm_pkg::ST_IDLE) && wake_req |=> !init_done ##1
      (state == fpm_pkg::ST_WAKE_LO);
  endproperty
  a_rewake: assert property (p_rewake)
    else $error("Refresh overrun did not restart wake-up");

  // Refresh rows fall on a low column strobe on purpose
  property p_fresh;
    @(posedge core_clk) disable iff (sys_rst)
    $fell(row_strobe_n) && (state != fpm_pkg::ST_REF_RAS) |->
      $past(column_strobe_n);
  endproperty
  a_fresh: assert property (p_fresh)
    else $error("Row strobe fell without column strobe high first");

  property p_read_hold;
    @(posedge core_clk) disable iff (sys_rst)
    $rose(column_strobe_n) && $past(write_enable_n) |-> write_enable_n;
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("Write enable fell at end of read column strobe");

  property p_early_write;
    @(posedge core_clk) disable iff (sys_rst)
    $fell(column_strobe_n) && !write_enable_n && !row_strobe_n |->
      $past(!write_enable_n) && $past(shared_data_lines_oe);
  endproperty
  a_early_write: assert property (p_early_write)
    else $error("Write enable or data late for early write");

  property p_data_hold;
    @(posedge core_clk) disable iff (sys_rst)
    $fell(column_strobe_n) && shared_data_lines_oe |=>
      shared_data_lines_oe && $stable(shared_data_lines_out);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("Write data not held after column strobe fell");

  property p_row_addr;
    @(posedge core_clk) disable iff (sys_rst)
    $fell(row_strobe_n) && init_done && column_strobe_n |=>
      $past(multiplexed_address_lines) == open_row;
  endproperty
  a_row_addr: assert property (p_row_addr)
    else $error("Row half not on address lines at row strobe");

  property p_we_kind;
    @(posedge core_clk) disable iff (sys_rst)
    $fell(column_strobe_n) && !row_strobe_n |-> write_enable_n == !cur_write;
  endproperty
  a_we_kind: assert property (p_we_kind)
    else $error("Write enable does not match access kind");

  property p_refresh;
    @(posedge core_clk) disable iff (sys_rst)
    ref_pending && init_done |-> ##[0:120] (state == fpm_pkg::ST_REF_RAS);
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("Owed refresh not issued in time");
endmodule

// file: test/fpm_dram_model.sv
// Behavioural page-mode DRAM module facing the controller
module fpm_dram_model (
  // Strobes and address
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_enable_n,
  input wire fpm_pkg::fpm_half_t multiplexed_address_lines,
  // Data lines
  input wire fpm_pkg::fpm_byte_t dq_in,
  output fpm_pkg::fpm_byte_t dq_out,
  output logic dq_oe,
  // Activity counts
  output int ras_cycles,
  output int row_opens,
  output int refreshes,
  output int hold_err
);
  timeunit 1ns;
  timeprecision 1ps;
  // Stored words keyed by row and column
  fpm_pkg::fpm_byte_t mem [int];
  fpm_pkg::fpm_half_t row;
  fpm_pkg::fpm_half_t ref_row;
  fpm_pkg::fpm_byte_t last;
  fpm_pkg::fpm_byte_t cap;
  int key;

  // Standby at time zero
  initial
  begin
    dq_oe = 1'b0;
    last = 8'h00;
    dq_out = 8'hff;
    ref_row = '0;
  end

  // Row strobe fall: open a row, or refresh if column already low
  always @(negedge row_strobe_n)
  begin
    // Row half and strobe change on one edge: let the address settle
    #1;
    ras_cycles++;
    if (column_strobe_n === 1'b0)
    begin
      // Address ignored, own counter moves on, output kept
      refreshes++;
      ref_row++;
    end
    else
    begin
      row = multiplexed_address_lines;
      row_opens++;
    end
  end

  // Column strobe fall inside an open row
  always @(negedge column_strobe_n)
  begin
    key = int'({row, multiplexed_address_lines});
    if (row_strobe_n === 1'b0 && write_enable_n === 1'b0)
    begin
      // Early write takes data at the column fall
      mem[key] = dq_in;
      cap = dq_in;
      #20;
      if (dq_in !== cap)
        hold_err++;
    end
    else if (row_strobe_n === 1'b0)
    begin
      last = mem.exists(key) ? mem[key] : 8'hc3;
      // Access counted from the column fall
      #25;
      if (column_strobe_n === 1'b0)
      begin
        dq_out = last;
        dq_oe = 1'b1;
      end
    end
  end

  // Column high: lines float, shown as inverse of last value
  always @(posedge column_strobe_n)
  begin
    dq_oe = 1'b0;
    dq_out = ~last;
  end
endmodule

// file: test/fpm_dram_module_interface_tb_top.sv
// Self-checking bench for the page-mode DRAM controller
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
module fpm_dram_module_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PWR = 20;
  localparam int PAGE = 200;
  localparam int LIM = 2000;
  // User side and strobes
  logic core_clk, sys_rst, req_valid, req_ready, req_write, rd_valid;
  logic init_done, row_strobe_n, column_strobe_n, write_enable_n, oe;
  fpm_pkg::fpm_word_addr_t req_addr;
  fpm_pkg::fpm_byte_t req_wdata, rd_data, dq_out, dq_m, dq_wire;
  fpm_pkg::fpm_half_t mux_addr;
  logic dq_oe_m;
  // Model counts and bench tallies
  int ras_cycles, row_opens, refreshes, hold_err;
  int miscompares, n_checks, clash;
  // Test addresses and data
  fpm_pkg::fpm_word_addr_t adr [4] = '{20'hfffff, 20'h00000, 20'h003ff,
    20'hffc00};
  fpm_pkg::fpm_byte_t dat [4] = '{8'h00, 8'hff, 8'ha5, 8'h3c};

  // Wire level from both drivers
  assign dq_wire = oe ? dq_out : dq_m;

  fpm_ctrl #(.PWR_CYC(PWR), .PAGE_MAX_CYC(PAGE), .REF_INT_CYC(2000)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
    .init_done(init_done), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .write_enable_n(write_enable_n),
    .multiplexed_address_lines(mux_addr), .shared_data_lines_in(dq_wire),
    .shared_data_lines_out(dq_out), .shared_data_lines_oe(oe));

  fpm_dram_model u_dram (
    .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
    .write_enable_n(write_enable_n), .multiplexed_address_lines(mux_addr),
    .dq_in(dq_wire), .dq_out(dq_m), .dq_oe(dq_oe_m),
    .ras_cycles(ras_cycles), .row_opens(row_opens),
    .refreshes(refreshes), .hold_err(hold_err));

  // 50 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Count cycles where both sides drive the data lines
  always @(posedge core_clk)
  begin
    if (oe === 1'b1 && dq_oe_m === 1'b1)
      clash++;
  end

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Spent wait bound counts as a mismatch
  task automatic bail(input int n);
    if (n >= LIM)
    begin
      miscompares++;
      results();
    end
  endtask

  // Bounded wait for a signal to reach a level
  task automatic wait_val(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < LIM)
    begin
      @(posedge core_clk);
      n++;
    end
    bail(n);
  endtask

  // Offer one request, hold it until taken
  task automatic do_req(input logic w, input fpm_pkg::fpm_word_addr_t a,
    input fpm_pkg::fpm_byte_t d);
    int n;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < LIM);
    bail(n);
    req_valid <= 1'b0;
    @(posedge core_clk);
  endtask

  // Read one word and compare
  task automatic rd_chk(input fpm_pkg::fpm_word_addr_t a,
    input fpm_pkg::fpm_byte_t exp);
    int n;
    do_req(1'b0, a, 8'h00);
    wait_val(rd_valid, 1'b1, n);
    `CHK(rd_data, exp)
    `CHK(write_enable_n, 1'b1)
  endtask

  // Power-up pause, then eight row cycles before requests
  task automatic t_wake(input int base);
    int n;
    wait_val(row_strobe_n, 1'b0, n);
    `CHK(n >= PWR, 1'b1)
    `CHK(req_ready, 1'b0)
    wait_val(init_done, 1'b1, n);
    `CHK(ras_cycles - base, 8)
    $display("test wake done");
  endtask

  // Back-to-back writes in one row, then a row change
  task automatic t_page();
    int base;
    do_req(1'b1, 20'h12345, 8'h11);
    do_req(1'b1, 20'h12346, 8'h22);
    base = row_opens;
    rd_chk(20'h12345, 8'h11);
    rd_chk(20'h12346, 8'h22);
    `CHK(row_opens - base, 0)
    rd_chk(20'h54321, 8'hc3);
    `CHK(row_opens - base, 1)
    $display("test page done");
  endtask

  // Boundary addresses written then read back
  task automatic t_wr_rd();
    for (int i = 0; i < 4; i++)
      do_req(1'b1, adr[i], dat[i]);
    for (int i = 0; i < 4; i++)
    begin
      rd_chk(adr[i], dat[i]);
      `CHK(u_dram.mem.exists(int'(adr[i])), 1)
    end
    $display("test write read done");
  endtask

  // Reads keep running across a refresh
  task automatic t_refresh();
    int base;
    int n;
    base = refreshes;
    n = 0;
    while (refreshes == base && n < 200)
    begin
      rd_chk(20'h12345, 8'h11);
      n++;
    end
    `CHK(n < 200, 1'b1)
    `CHK(u_dram.ref_row, refreshes[9:0])
    rd_chk(20'h12345, 8'h11);
    $display("test refresh done");
  endtask

  // Open page closes before the longest row-low time
  task automatic t_page_limit();
    int n;
    rd_chk(20'h00000, 8'hff);
    wait_val(row_strobe_n, 1'b1, n);
    `CHK(n <= PAGE, 1'b1)
    $display("test page limit done");
  endtask

  // Reset in mid-run redoes the wake-up
  task automatic t_rst_mid();
    do_req(1'b0, 20'h12345, 8'h00);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    `CHK(row_strobe_n, 1'b1)
    `CHK(init_done, 1'b0)
    sys_rst <= 1'b0;
    t_wake(ras_cycles);
    rd_chk(20'h12346, 8'h22);
    $display("test mid reset done");
  endtask

  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_wake(0);
    t_page();
    t_wr_rd();
    t_refresh();
    t_page_limit();
    t_rst_mid();
    `CHK(clash, 0)
    `CHK(hold_err, 0)
    results();
  end
endmodule
